// ---- verilog/status_bank_consts.vh ----
`ifndef STATUS_BANK_CONSTS_VH
`define STATUS_BANK_CONSTS_VH

// register indexes on the status read port
`define ADDR_W           4
`define REG_OUT1_TIMING  4'h3
`define REG_OUT2_TIMING  4'h4
`define REG_OUT1_PWM     4'ha

// status word geometry and reset value
`define WORD_W           16
`define STATUS_RESET     16'h0000

// timing word fields
`define NODE_HI          15
`define NODE_LO          14
`define PEAK_HI          13
`define PEAK_LO          12
`define CLAMP_HI         11
`define CLAMP_LO         10
`define HOLD_HI          9
`define HOLD_LO          8

// two-bit duration warning codes
`define CODE_OK          2'h0
`define CODE_MIN         2'h1
`define CODE_MAX         2'h2

// pwm word layout
`define PWM_LOCKOUT_BIT  15
`define PWM_PEAK_BASE    8
`define PWM_HOLD_BASE    0
`define PWM_EVT_W        7

// event order inside each seven-bit half of the pwm word
`define EVT_SKIP         6
`define EVT_RIPPLE_HI    5
`define EVT_RIPPLE_LO    4
`define EVT_HI_TIMEOUT   3
`define EVT_LOW_CURRENT  2
`define EVT_LO_TIMEOUT   1
`define EVT_SELFTEST     0

// edges to wait after reset release before the address strap is taken
`define STRAP_SETTLE     2'h3

`endif

// ---- verilog/duration_check.v ----
`timescale 1ns/10ps
`include "status_bank_consts.vh"

// compares one finished duration against its limits and latches the code
module duration_check #(
	parameter DUR_W = 8
) (
	input  wire             core_clk_in,
	input  wire             rst_in,
	input  wire             done_in,
	input  wire [DUR_W-1:0] dur_in,
	input  wire [DUR_W-1:0] min_in,
	input  wire [DUR_W-1:0] max_in,
	input  wire             clear_in,
	output reg  [1:0]       code_out
);

	reg [1:0] viol;      // verdict of this cycle's measurement

	// classify; short is tested first, so a duration below min and above max reads as short
	always @* begin
		viol = `CODE_OK;
		if (done_in) begin
			if (dur_in < min_in)
				viol = `CODE_MIN;
			else if (dur_in > max_in)
				viol = `CODE_MAX;
		end
	end

	// first nonzero code sticks; clear empties it
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			code_out <= `CODE_OK;
		end else if (clear_in) begin
			// a violation landing with the clear is kept, not lost
			code_out <= viol; // RQ8
		end else if (code_out == `CODE_OK) begin
			code_out <= viol; // RQ8
		end
	end

endmodule // duration_check

// ---- verilog/warn_status_bank.v ----
`timescale 1ns/10ps
`include "status_bank_consts.vh"

// How it works
// RQ1 - node address in top two bits
// RQ2 - out1 peak ramp: short 1, long 2
// RQ3 - out1 clamp time: short 1, long 2
// RQ4 - out1 hold ramp: short 1, long 2
// RQ5 - out2 peak ramp uses own peak setting
// RQ6 - out2 clamp time, shared clamp limits
// RQ7 - out2 hold ramp, shared hold limits
// RQ8 - nonzero codes hold until clear command
// RQ9 - one peak minimum, per-output peak maximum
// RQ10 - bit 15 flags out1 undercurrent lockout
// RQ11 - peak phase skip, ripple, low current bits
// RQ12 - peak phase sense timeouts, comparator test
// RQ13 - hold phase skip, ripple, low current bits
// RQ14 - hold phase sense timeouts, comparator test
// RQ15 - reserved bits zero, words reset zero
// RQ16 - summary bit ORs every warning flag
// RQ17 - reads harmless, writes ignored
module warn_status_bank #(
	parameter DUR_W = 8
) (
	input  wire                 core_clk_in,
	input  wire                 rst_in,
	input  wire [1:0]           node_address_in,
	input  wire                 clear_latched_faults_cmd_in,
	input  wire [DUR_W-1:0]     peak_ramp_min_limit_in,
	input  wire [DUR_W-1:0]     clamp_time_min_limit_in,
	input  wire [DUR_W-1:0]     clamp_time_max_limit_in,
	input  wire [DUR_W-1:0]     hold_ramp_min_limit_in,
	input  wire [DUR_W-1:0]     hold_ramp_max_limit_in,
	input  wire [DUR_W-1:0]     out1_peak_time_setting_in,
	input  wire [DUR_W-1:0]     out2_peak_time_setting_in,
	input  wire [1:0]           peak_ramp_done_in,
	input  wire [2*DUR_W-1:0]   peak_ramp_dur_in,
	input  wire [1:0]           clamp_time_done_in,
	input  wire [2*DUR_W-1:0]   clamp_time_dur_in,
	input  wire [1:0]           hold_ramp_done_in,
	input  wire [2*DUR_W-1:0]   hold_ramp_dur_in,
	input  wire                 out1_peak_phase_in,
	input  wire                 out1_hold_phase_in,
	input  wire                 out1_undercurrent_lockout_in,
	input  wire [`PWM_EVT_W-1:0] out1_peak_evt_in,
	input  wire [`PWM_EVT_W-1:0] out1_hold_evt_in,
	input  wire                 other_warnings_in,
	input  wire                 rd_en_in,
	input  wire [`ADDR_W-1:0]   rd_addr_in,
	input  wire                 wr_en_in,
	input  wire [`ADDR_W-1:0]   wr_addr_in,
	output reg  [`WORD_W-1:0]   rd_data_out,
	output reg                  rd_valid_out,
	output reg                  wr_reject_out,
	output reg                  warnings_summary_out
);

	// ---- address strap ----

	reg [1:0] node_sync1;      // first stage, read only by second
	reg [1:0] node_sync2;      // settled copy of the decoded strap
	reg [1:0] node_address;    // address frozen after release
	reg [1:0] strap_cnt;       // edges since reset release
	reg       strap_taken;     // address has been captured

	// two-flop synchroniser; the decoder output is not on our clock
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			node_sync1 <= 2'h0;
			node_sync2 <= 2'h0;
		end else begin
			node_sync1 <= node_address_in;
			node_sync2 <= node_sync1;
		end
	end

	// capture the strap once, after the synchroniser has filled;
	// a strap cannot be caught under the async reset itself
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			strap_cnt    <= 2'h0;
			strap_taken  <= 1'b0;
			node_address <= 2'h0;
		end else if (!strap_taken) begin
			if (strap_cnt == `STRAP_SETTLE) begin
				node_address <= node_sync2; // RQ1
				strap_taken  <= 1'b1;
			end else begin
				strap_cnt <= strap_cnt + 2'h1;
			end
		end
	end

	// ---- duration checks ----

	wire [2*DUR_W-1:0] peak_max_limit;  // per-output peak maximum
	wire [3:0]         peak_code;       // two bits per output
	wire [3:0]         clamp_code;      // two bits per output
	wire [3:0]         hold_code;       // two bits per output

	// each output judges its peak ramp against its own peak time
	assign peak_max_limit = {out2_peak_time_setting_in,
		out1_peak_time_setting_in}; // RQ9

	// one checker per output and per duration kind
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_out
			// peak ramp: shared minimum, own maximum
			duration_check #(
				.DUR_W (DUR_W)
			) u_peak (
				.core_clk_in (core_clk_in),
				.rst_in      (rst_in),
				.done_in     (peak_ramp_done_in[ch]),
				.dur_in      (peak_ramp_dur_in[ch*DUR_W +: DUR_W]),
				.min_in      (peak_ramp_min_limit_in), // RQ9
				.max_in      (peak_max_limit[ch*DUR_W +: DUR_W]),
				.clear_in    (clear_latched_faults_cmd_in),
				.code_out    (peak_code[ch*2 +: 2])
			);

			// quick turn-off clamping: limits shared by both outputs
			duration_check #(
				.DUR_W (DUR_W)
			) u_clamp (
				.core_clk_in (core_clk_in),
				.rst_in      (rst_in),
				.done_in     (clamp_time_done_in[ch]),
				.dur_in      (clamp_time_dur_in[ch*DUR_W +: DUR_W]),
				.min_in      (clamp_time_min_limit_in),
				.max_in      (clamp_time_max_limit_in),
				.clear_in    (clear_latched_faults_cmd_in),
				.code_out    (clamp_code[ch*2 +: 2])
			);

			// hold ramp: limits shared by both outputs
			duration_check #(
				.DUR_W (DUR_W)
			) u_hold (
				.core_clk_in (core_clk_in),
				.rst_in      (rst_in),
				.done_in     (hold_ramp_done_in[ch]),
				.dur_in      (hold_ramp_dur_in[ch*DUR_W +: DUR_W]),
				.min_in      (hold_ramp_min_limit_in),
				.max_in      (hold_ramp_max_limit_in),
				.clear_in    (clear_latched_faults_cmd_in),
				.code_out    (hold_code[ch*2 +: 2])
			);
		end
	endgenerate

	// ---- pwm cycle warnings for output 1 ----

	reg  [`WORD_W-1:0] pwm_word;     // sticky pwm flags
	wire [`WORD_W-1:0] pwm_set;      // this cycle's new events
	wire               clr;          // short alias for the clear

	assign clr = clear_latched_faults_cmd_in;

	// undercurrent lockout is not tied to a regulation phase
	assign pwm_set[`PWM_LOCKOUT_BIT] = out1_undercurrent_lockout_in; // RQ10
	// bit 7 has no source and stays zero
	assign pwm_set[`PWM_PEAK_BASE-1] = 1'b0; // RQ13

	// peak events count only in peak phase, hold events in hold
	// phase; event order inside each half is the same
	genvar k;
	generate
		for (k = 0; k < `PWM_EVT_W; k = k + 1) begin : g_pwm
			assign pwm_set[`PWM_PEAK_BASE+k] =
				out1_peak_phase_in & out1_peak_evt_in[k]; // RQ11 RQ12
			assign pwm_set[`PWM_HOLD_BASE+k] =
				out1_hold_phase_in & out1_hold_evt_in[k]; // RQ13 RQ14
		end
	endgenerate

	// latch the flags; a set in the clear cycle survives the clear
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pwm_word <= `STATUS_RESET; // RQ15
		end else if (clr) begin
			pwm_word <= pwm_set;
		end else begin
			pwm_word <= pwm_word | pwm_set;
		end
	end

	// ---- status words ----

	// timing codes under their field names; lane 0 is output 1
	wire [1:0] out1_peak_ramp_warn;   // output 1 peak ramp code
	wire [1:0] out1_clamp_time_warn;  // output 1 clamp time code
	wire [1:0] out1_hold_ramp_warn;   // output 1 hold ramp code
	wire [1:0] out2_peak_ramp_warn;   // output 2 peak ramp code
	wire [1:0] out2_clamp_time_warn;  // output 2 clamp time code
	wire [1:0] out2_hold_ramp_warn;   // output 2 hold ramp code

	assign out1_peak_ramp_warn  = peak_code[1:0];  // RQ2
	assign out1_clamp_time_warn = clamp_code[1:0]; // RQ3
	assign out1_hold_ramp_warn  = hold_code[1:0];  // RQ4
	assign out2_peak_ramp_warn  = peak_code[3:2];  // RQ5
	assign out2_clamp_time_warn = clamp_code[3:2]; // RQ6
	assign out2_hold_ramp_warn  = hold_code[3:2];  // RQ7

	// sticky pwm flags under their field names
	wire out1_undercurrent_lockout_warn; // lockout, in any phase
	wire out1_peak_skip_warn;            // peak phase cycle skip
	wire out1_peak_ripple_hi_warn;       // peak phase ripple high
	wire out1_peak_ripple_lo_warn;       // peak phase ripple low
	wire out1_peak_hiside_timeout_warn;  // peak phase high-side sense
	wire out1_peak_lowcurrent_warn;      // peak phase low current
	wire out1_peak_loside_timeout_warn;  // peak phase low-side sense
	wire out1_comparator_selftest_warn;  // peak phase comparator test
	wire out1_hold_skip_warn;            // hold phase cycle skip
	wire out1_hold_ripple_hi_warn;       // hold phase ripple high
	wire out1_hold_ripple_lo_warn;       // hold phase ripple low
	wire out1_hold_hiside_timeout_warn;  // hold phase high-side sense
	wire out1_hold_lowcurrent_warn;      // hold phase low current
	wire out1_hold_loside_timeout_warn;  // hold phase low-side sense
	wire out1_hold_selftest_warn;        // hold phase comparator test

	// peak half sits above the reserved bit, hold half below it
	assign out1_undercurrent_lockout_warn = pwm_word[`PWM_LOCKOUT_BIT];
	assign out1_peak_skip_warn =
		pwm_word[`PWM_PEAK_BASE+`EVT_SKIP];
	assign out1_peak_ripple_hi_warn =
		pwm_word[`PWM_PEAK_BASE+`EVT_RIPPLE_HI];
	assign out1_peak_ripple_lo_warn =
		pwm_word[`PWM_PEAK_BASE+`EVT_RIPPLE_LO];
	assign out1_peak_hiside_timeout_warn =
		pwm_word[`PWM_PEAK_BASE+`EVT_HI_TIMEOUT];
	assign out1_peak_lowcurrent_warn =
		pwm_word[`PWM_PEAK_BASE+`EVT_LOW_CURRENT];
	assign out1_peak_loside_timeout_warn =
		pwm_word[`PWM_PEAK_BASE+`EVT_LO_TIMEOUT];
	assign out1_comparator_selftest_warn =
		pwm_word[`PWM_PEAK_BASE+`EVT_SELFTEST];
	assign out1_hold_skip_warn =
		pwm_word[`PWM_HOLD_BASE+`EVT_SKIP];
	assign out1_hold_ripple_hi_warn =
		pwm_word[`PWM_HOLD_BASE+`EVT_RIPPLE_HI];
	assign out1_hold_ripple_lo_warn =
		pwm_word[`PWM_HOLD_BASE+`EVT_RIPPLE_LO];
	assign out1_hold_hiside_timeout_warn =
		pwm_word[`PWM_HOLD_BASE+`EVT_HI_TIMEOUT];
	assign out1_hold_lowcurrent_warn =
		pwm_word[`PWM_HOLD_BASE+`EVT_LOW_CURRENT];
	assign out1_hold_loside_timeout_warn =
		pwm_word[`PWM_HOLD_BASE+`EVT_LO_TIMEOUT];
	assign out1_hold_selftest_warn =
		pwm_word[`PWM_HOLD_BASE+`EVT_SELFTEST];

	wire [`WORD_W-1:0] out1_timing_warnings;    // word at index 3
	wire [`WORD_W-1:0] out2_timing_warnings;    // word at index 4
	wire [`WORD_W-1:0] out1_pwm_cycle_warnings; // word at index a

	// output 1 timing word; low byte reserved at zero
	assign out1_timing_warnings = {
		node_address,          // RQ1
		out1_peak_ramp_warn,   // RQ2
		out1_clamp_time_warn,  // RQ3
		out1_hold_ramp_warn,   // RQ4
		8'h00                  // RQ15
	};

	// output 2 timing word; same layout as output 1
	assign out2_timing_warnings = {
		node_address,          // RQ1
		out2_peak_ramp_warn,   // RQ5
		out2_clamp_time_warn,  // RQ6
		out2_hold_ramp_warn,   // RQ7
		8'h00                  // RQ15
	};

	// pwm word rebuilt field by field; bit 7 has no source
	assign out1_pwm_cycle_warnings = {
		out1_undercurrent_lockout_warn, // RQ10
		out1_peak_skip_warn,            // RQ11
		out1_peak_ripple_hi_warn,       // RQ11
		out1_peak_ripple_lo_warn,       // RQ11
		out1_peak_hiside_timeout_warn,  // RQ12
		out1_peak_lowcurrent_warn,      // RQ11
		out1_peak_loside_timeout_warn,  // RQ12
		out1_comparator_selftest_warn,  // RQ12
		1'b0,                           // RQ13
		out1_hold_skip_warn,            // RQ13
		out1_hold_ripple_hi_warn,       // RQ13
		out1_hold_ripple_lo_warn,       // RQ13
		out1_hold_hiside_timeout_warn,  // RQ14
		out1_hold_lowcurrent_warn,      // RQ13
		out1_hold_loside_timeout_warn,  // RQ14
		out1_hold_selftest_warn         // RQ14
	};

	// ---- read port ----

	reg [`WORD_W-1:0] next_rd_data;  // word selected by address

	// decode; unmapped indexes read as zero
	always @* begin
		case (rd_addr_in)
			`REG_OUT1_TIMING: next_rd_data = out1_timing_warnings;
			`REG_OUT2_TIMING: next_rd_data = out2_timing_warnings;
			`REG_OUT1_PWM:    next_rd_data = out1_pwm_cycle_warnings;
			default:          next_rd_data = `STATUS_RESET;
		endcase
	end

	// register the answer one edge after the request; reading
	// touches no flag, so a read can never lose a warning
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_data_out  <= `STATUS_RESET;
			rd_valid_out <= 1'b0;
		end else begin
			rd_valid_out <= rd_en_in; // RQ17
			if (rd_en_in)
				rd_data_out <= next_rd_data; // RQ17
		end
	end

	// ---- write port ----

	wire wr_hits_bank;  // write aimed at one of our words

	assign wr_hits_bank = (wr_addr_in == `REG_OUT1_TIMING) ||
		(wr_addr_in == `REG_OUT2_TIMING) ||
		(wr_addr_in == `REG_OUT1_PWM);

	// every field is read-only: a write only reports its refusal
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in)
			wr_reject_out <= 1'b0;
		else
			wr_reject_out <= wr_en_in & wr_hits_bank; // RQ17
	end

	// ---- warning summary ----

	wire any_local_warning;  // any flag of this bank set

	// node address and reserved bits are not warnings
	assign any_local_warning = (|peak_code) | (|clamp_code) |
		(|hold_code) | (|pwm_word);

	// registered, so it trails the flags by one edge
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in)
			warnings_summary_out <= 1'b0;
		else
			warnings_summary_out <= any_local_warning |
				other_warnings_in; // RQ16
	end

endmodule // warn_status_bank

// ---- bench/warn_status_chk.sv ----
`timescale 1ns/10ps
`include "status_bank_consts.vh"

// port watcher for the status bank
module warn_status_chk #(
	parameter DUR_W = 8
) (
	input wire                  core_clk_in,
	input wire                  rst_in,
	input wire                  clear_latched_faults_cmd_in,
	input wire                  out1_hold_phase_in,
	input wire                  out1_undercurrent_lockout_in,
	input wire [`PWM_EVT_W-1:0] out1_hold_evt_in,
	input wire                  other_warnings_in,
	input wire                  rd_en_in,
	input wire [`ADDR_W-1:0]    rd_addr_in,
	input wire                  wr_en_in,
	input wire [`ADDR_W-1:0]    wr_addr_in,
	input wire [`WORD_W-1:0]    rd_data_out,
	input wire                  rd_valid_out,
	input wire                  wr_reject_out,
	input wire                  warnings_summary_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	// timing word read
	wire rd_t = rd_en_in && (rd_addr_in == `REG_OUT1_TIMING
		|| rd_addr_in == `REG_OUT2_TIMING);
	// pwm word read
	wire rd_p = rd_en_in && rd_addr_in == `REG_OUT1_PWM;
	// write aimed at a bank word
	wire wr_b = wr_en_in && (wr_addr_in == `REG_OUT1_TIMING
		|| wr_addr_in == `REG_OUT2_TIMING || wr_addr_in == `REG_OUT1_PWM);
	property p_ans; rd_en_in |=> rd_valid_out; endproperty
	a_ans: assert property (p_ans) else $error("read not answered");
	property p_one; !rd_en_in |=> !rd_valid_out; endproperty
	a_one: assert property (p_one) else $error("stray answer");
	property p_rsv; rd_t |=> rd_data_out[7:0] == 8'h00; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved set");
	property p_gap; rd_p |=> !rd_data_out[7]; endproperty
	a_gap: assert property (p_gap) else $error("pwm bit 7 set");
	property p_unm;
		rd_en_in && !rd_t && !rd_p |=> rd_data_out == `STATUS_RESET;
	endproperty
	a_unm: assert property (p_unm) else $error("unmapped nonzero");
	property p_rej; wr_b |=> wr_reject_out; endproperty
	a_rej: assert property (p_rej) else $error("write not dropped");
	property p_sum; other_warnings_in |=> warnings_summary_out; endproperty
	a_sum: assert property (p_sum) else $error("summary low");
	property p_lock;
		out1_undercurrent_lockout_in ##1 rd_p && !clear_latched_faults_cmd_in
		|=> rd_data_out[`PWM_LOCKOUT_BIT];
	endproperty
	a_lock: assert property (p_lock) else $error("lockout lost");
	property p_hold;
		out1_hold_phase_in && out1_hold_evt_in[6] ##1 rd_p
		&& !clear_latched_faults_cmd_in |=> rd_data_out[6];
	endproperty
	a_hold: assert property (p_hold) else $error("hold skip lost");
	c_rd: cover property (rd_valid_out);
	c_rej: cover property (wr_reject_out);
	c_sum: cover property ($rose(warnings_summary_out));
endmodule // warn_status_chk

bind warn_status_bank warn_status_chk #(.DUR_W(DUR_W)) u_chk (
	.core_clk_in, .rst_in, .clear_latched_faults_cmd_in,
	.out1_hold_phase_in, .out1_undercurrent_lockout_in,
	.out1_hold_evt_in, .other_warnings_in, .rd_en_in, .rd_addr_in,
	.wr_en_in, .wr_addr_in, .rd_data_out, .rd_valid_out,
	.wr_reject_out, .warnings_summary_out);

// ---- bench/status_host.sv ----
`timescale 1ns/10ps

// host side of the status read and write ports
module status_host (
	input  wire        core_clk_in,
	input  wire [15:0] rd_data_in,
	input  wire        rd_valid_in,
	input  wire        wr_reject_in,
	output reg         rd_en_out,
	output reg  [3:0]  rd_addr_out,
	output reg         wr_en_out,
	output reg  [3:0]  wr_addr_out
);
	// idle, no request
	initial begin
		rd_en_out = 1'b0;
		rd_addr_out = 4'h0;
		wr_en_out = 1'b0;
		wr_addr_out = 4'h0;
	end
	// one read; index inverted after so a stale one is never reused
	task rd(input [3:0] a, output [15:0] d);
		begin
			@(negedge core_clk_in);
			rd_en_out = 1'b1;
			rd_addr_out = a;
			@(negedge core_clk_in);
			d = rd_valid_in ? rd_data_in : 16'hxxxx; // no answer never matches
			rd_en_out = 1'b0;
			rd_addr_out = ~a;
		end
	endtask
	// one write, reject flag taken in the answer cycle
	task wr(input [3:0] a, output r);
		begin
			@(negedge core_clk_in);
			wr_en_out = 1'b1;
			wr_addr_out = a;
			@(negedge core_clk_in);
			r = wr_reject_in;
			wr_en_out = 1'b0;
			wr_addr_out = ~a;
		end
	endtask
endmodule // status_host

// ---- bench/test_warn_status_bank.sv ----
`timescale 1ns/10ps
`include "status_bank_consts.vh"

// status bank bench
module test_warn_status_bank;
	reg         core_clk_in, rst_in, clr, oth, pph, hph, lck, r;
	reg  [1:0]  strap, pd, cd, hd;
	reg  [7:0]  lo, hi, pt2;
	reg  [15:0] pv, cv, hv, d;
	reg  [6:0]  pe, he;
	wire [15:0] rdat;
	wire        rv, rej, sum, ren, wen;
	wire [3:0]  ra, wa;
	integer     n_mismatch, tests_run, k;

	warn_status_bank uut (.core_clk_in(core_clk_in), .rst_in(rst_in),
		.node_address_in(strap), .clear_latched_faults_cmd_in(clr),
		.peak_ramp_min_limit_in(lo), .clamp_time_min_limit_in(lo),
		.clamp_time_max_limit_in(hi), .hold_ramp_min_limit_in(lo),
		.hold_ramp_max_limit_in(hi), .out1_peak_time_setting_in(hi),
		.out2_peak_time_setting_in(pt2), .peak_ramp_done_in(pd),
		.peak_ramp_dur_in(pv), .clamp_time_done_in(cd),
		.clamp_time_dur_in(cv), .hold_ramp_done_in(hd),
		.hold_ramp_dur_in(hv), .out1_peak_phase_in(pph),
		.out1_hold_phase_in(hph), .out1_undercurrent_lockout_in(lck),
		.out1_peak_evt_in(pe), .out1_hold_evt_in(he),
		.other_warnings_in(oth), .rd_en_in(ren), .rd_addr_in(ra),
		.wr_en_in(wen), .wr_addr_in(wa), .rd_data_out(rdat),
		.rd_valid_out(rv), .wr_reject_out(rej),
		.warnings_summary_out(sum));
	status_host host (.core_clk_in(core_clk_in), .rd_data_in(rdat),
		.rd_valid_in(rv), .wr_reject_in(rej), .rd_en_out(ren),
		.rd_addr_out(ra), .wr_en_out(wen), .wr_addr_out(wa));

	// 25 MHz clock
	initial begin
		core_clk_in = 1'b0;
		forever #20 core_clk_in = ~core_clk_in;
	end
	// compare and count
	task chk(input [15:0] s, input [15:0] e);
		begin
			tests_run = tests_run + 1;
			if (s !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("wrong value at %0t: saw %h want %h", $time, s, e);
			end
		end
	endtask
	// read a word and compare
	task rc(input [3:0] a, input [15:0] e);
		begin
			host.rd(a, d);
			chk(d, e);
		end
	endtask
	// one cycle of finished measurements
	task ms(input [1:0] p, c, h, input [15:0] a, b, e);
		begin
			@(negedge core_clk_in);
			pd = p;
			cd = c;
			hd = h;
			pv = a;
			cv = b;
			hv = e;
			@(negedge core_clk_in);
			pd = 2'h0;
			cd = 2'h0;
			hd = 2'h0;
			pv = ~a;
			cv = ~b;
			hv = ~e;
		end
	endtask
	// clear pulse
	task cl;
		begin
			@(negedge core_clk_in);
			clr = 1'b1;
			@(negedge core_clk_in);
			clr = 1'b0;
		end
	endtask
	// one cycle in peak phase, then hold phase with lockout level
	task ev(input [6:0] a, b, c, e, input u);
		begin
			@(negedge core_clk_in);
			pph = 1'b1;
			pe = a;
			he = b;
			@(negedge core_clk_in);
			pph = 1'b0;
			pe = c;
			hph = 1'b1;
			he = e;
			lck = u;
		end
	endtask
	// counts and verdict
	task results;
		begin
			$display("compares %0d mismatches %0d", tests_run, n_mismatch);
			if (n_mismatch == 0 && tests_run > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	// hang guard, far beyond the hundred or so cycles needed
	initial begin
		#100000;
		n_mismatch = n_mismatch + 1;
		results;
	end
	// main sequence
	initial begin
		{rst_in, clr, oth, pph, hph, lck} = 6'h20;
		{pd, cd, hd, pv, cv, hv, pe, he} = 68'h0;
		strap = 2'h1; // asymmetric so a swapped field shows
		lo = 8'h0a;
		hi = 8'h14;
		pt2 = 8'h1e;
		n_mismatch = 0;
		tests_run = 0;
		repeat (20) @(negedge core_clk_in);
		rst_in = 1'b0;
		repeat (6) @(negedge core_clk_in);
		rc(`REG_OUT1_TIMING, 16'h4000);
		rc(`REG_OUT2_TIMING, 16'h4000);
		rc(`REG_OUT1_PWM, `STATUS_RESET);
		rc(4'h5, 16'h0000);
		chk({15'h0, sum}, 16'h0);
		$display("test 1 done");
		// out2 peak 25 is long only against the out1 setting
		ms(2'h3, 2'h3, 2'h3, 16'h1905, 16'h0915, 16'h1509);
		rc(`REG_OUT1_TIMING, 16'h5900);
		rc(`REG_OUT2_TIMING, 16'h4600);
		ms(2'h3, 2'h3, 2'h3, 16'h1f19, 16'h0f0f, 16'h0f0f);
		rc(`REG_OUT1_TIMING, 16'h5900);
		rc(`REG_OUT2_TIMING, 16'h6600);
		chk({15'h0, sum}, 16'h1);
		for (k = 0; k < 4; k = k + 1) begin
			host.wr(16'h5a43 >> (4 * k), r);
			chk({15'h0, r}, k < 3);
		end
		rc(`REG_OUT1_TIMING, 16'h5900);
		$display("test 2 done");
		cl;
		rc(`REG_OUT1_TIMING, 16'h4000);
		rc(`REG_OUT2_TIMING, 16'h4000);
		chk({15'h0, sum}, 16'h0);
		$display("test 3 done");
		// each event group offered once outside its phase
		ev(7'h4b, 7'h7f, 7'h7f, 7'h75, 1'b1);
		rc(`REG_OUT1_PWM, 16'hcb75);
		{hph, lck, pe, he} = 16'h0;
		cl;
		rc(`REG_OUT1_PWM, 16'h0000);
		// the complementary bits, hold skip set again, lockout left low
		ev(7'h34, 7'h7f, 7'h7f, 7'h4a, 1'b0);
		rc(`REG_OUT1_PWM, 16'h344a);
		{hph, lck, pe, he} = 16'h0;
		cl;
		rc(`REG_OUT1_PWM, 16'h0000);
		chk({15'h0, sum}, 16'h0);
		oth = 1'b1;
		repeat (2) @(negedge core_clk_in);
		chk({15'h0, sum}, 16'h1);
		oth = 1'b0;
		$display("test 4 done");
		// a long out1 peak, then a second reset with a new strap
		ms(2'h1, 2'h0, 2'h0, 16'h0019, 16'h0000, 16'h0000);
		rc(`REG_OUT1_TIMING, 16'h6000);
		strap = 2'h2;
		@(negedge core_clk_in);
		rst_in = 1'b1;
		repeat (2) @(negedge core_clk_in);
		rst_in = 1'b0;
		rc(`REG_OUT1_TIMING, `STATUS_RESET);
		chk({15'h0, sum}, 16'h0);
		repeat (4) @(negedge core_clk_in);
		rc(`REG_OUT1_TIMING, 16'h8000);
		rc(`REG_OUT2_TIMING, 16'h8000);
		$display("test 5 done");
		results;
	end
endmodule // test_warn_status_bank
